// [design/strc_pkg.sv]
// constants and types for the scan trigger and result control block
package strc_pkg;
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned MS_PER_S = 1000;
   localparam int unsigned MS_CYCLES_DEF = CLK_HZ / MS_PER_S;
   localparam logic [15:0] SELFTEST_MS = 16'h000a;
   localparam logic [15:0] READ_LED_MS = 16'h0064;
   localparam logic [15:0] EVAL_PERIOD_MS = 16'h07d0;
   localparam logic [6:0] EVAL_SCANS = 7'h64;
   localparam int unsigned BLINK_SLOW_HZ = 2;
   localparam int unsigned BLINK_FAST_HZ = 5;
   localparam logic [15:0] BLINK_SLOW_HALF_MS = 16'(MS_PER_S / (2 * BLINK_SLOW_HZ));
   localparam logic [15:0] BLINK_FAST_HALF_MS = 16'(MS_PER_S / (2 * BLINK_FAST_HZ));
   localparam logic [6:0] Q_LOW_PCT = 7'h1e;
   localparam logic [6:0] Q_MID_PCT = 7'h46;
   localparam logic [6:0] Q_HIGH_PCT = 7'h5a;
   localparam logic [7:0] MIRROR_REST = 8'h32;
   localparam logic [7:0] MIRROR_AMPL_DEG = 8'h14;
   localparam logic [3:0] MIRROR_FREQ_HZ = 4'h1;
   localparam logic [15:0] VERDICT_GOOD = 16'h0000;
   localparam int unsigned FIELD_W = 16;
   localparam int unsigned TAG_W = 5;
   localparam int unsigned REC_W = TAG_W + FIELD_W;
   localparam int unsigned FIFO_DEPTH = 32;
   localparam logic [4:0] LAST_SUMMARY_IDX = 5'h04;
   localparam logic [4:0] LAST_GOOD_IDX = 5'h11;

   typedef enum logic [1:0] {MODE_SELFTEST, MODE_READING, MODE_PERCENT} strc_mode_t;
   typedef enum logic [1:0] {MIR_OSCILLATE, MIR_ONE_SHOT, MIR_FIXED} strc_mirror_t;
   typedef enum logic [1:0] {EV_OFF, EV_GOOD_READ, EV_NO_READ, EV_PULSE_END} strc_event_t;
   typedef enum logic [1:0] {BAND_OFF, BAND_SLOW, BAND_FAST, BAND_STEADY} strc_band_t;
   // record word tags, in output order
   typedef enum logic [4:0] {
      TAG_INTERVAL_TIME, TAG_MEAN_QUALITY, TAG_CODE_COUNT, TAG_RANGE_PROFILE_INDEX,
      TAG_SYMBOL_TYPE, TAG_QUALITY, TAG_READ_VERDICT, TAG_SYMBOL_LENGTH, TAG_SCAN_ANGLE,
      TAG_OBJECT_RANGE_MM, TAG_RELIABILITY, TAG_DECODE_EFFORT, TAG_CODE_CONTINUITY,
      TAG_DECODE_ORIENTATION_FLAG, TAG_PRECISE_READ_ANGLE, TAG_PRECISE_SWING_ANGLE,
      TAG_FOCUS_POSITION_MM, TAG_OBJECT_NUMBER, TAG_NO_CODE
   } strc_tag_t;
endpackage

// [design/strc_top.sv]
// scan trigger, result record and indicator control with its result fifo
`timescale 1ns/1ps

module strc_fifo
   import strc_pkg::*;
#(
   parameter int unsigned WIDTH = REC_W,
   parameter int unsigned DEPTH = FIFO_DEPTH
)
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [WIDTH-1:0] wr_data_in,
   input wire logic wr_valid_in,
   output logic wr_ready_out,
   output logic [WIDTH-1:0] rd_data_out,
   output logic rd_valid_out,
   input wire logic rd_ready_in
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [AW:0] count_q;
   logic do_wr;
   logic do_rd;

   assign wr_ready_out = (count_q != (AW+1)'(DEPTH));
   assign rd_valid_out = (count_q != '0);
   assign rd_data_out = mem[rd_ptr_q];
   assign do_wr = wr_valid_in && wr_ready_out;
   assign do_rd = rd_valid_out && rd_ready_in;

   always_ff @(posedge clk_in)
   begin
      if (do_wr)
      begin
         mem[wr_ptr_q] <= wr_data_in;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end
      else
      begin
         if (do_wr)
         begin
            wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (do_rd)
         begin
            rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
         end
         count_q <= count_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
   end
endmodule

module strc_top
   import strc_pkg::*;
#(
   parameter int unsigned MS_CYCLES = MS_CYCLES_DEF,
   parameter int unsigned FIFO_WORDS = FIFO_DEPTH
)
(
   input wire logic REF_CLK_IN,
   input wire logic RST_IN,
   input wire logic SENSOR_IN,
   input wire logic SER_START_IN,
   input wire logic SER_STOP_IN,
   input wire logic SRC_SERIAL_LOAD_IN,
   input wire logic STD_DECODER_LOAD_IN,
   input wire logic MODE_READING_REQ_IN,
   input wire logic MODE_PERCENT_REQ_IN,
   input wire logic AUX_DIAG_MODE_IN,
   input wire logic [3:0] HOST_MIN_CODES_IN,
   input wire logic [3:0] HOST_MAX_CODES_IN,
   input wire logic [3:0] CODE_COUNT_IN,
   input wire logic [6:0] MEAN_QUALITY_IN,
   input wire logic [3:0] RANGE_PROFILE_INDEX_IN,
   input wire logic [7:0] SYMBOL_TYPE_IN,
   input wire logic [6:0] QUALITY_IN,
   input wire logic [7:0] SYMBOL_LENGTH_IN,
   input wire logic [7:0] SCAN_ANGLE_IN,
   input wire logic [15:0] OBJECT_RANGE_MM_IN,
   input wire logic [9:0] RELIABILITY_IN,
   input wire logic [9:0] DECODE_EFFORT_IN,
   input wire logic [9:0] CODE_CONTINUITY_IN,
   input wire logic DECODE_ORIENTATION_FLAG_IN,
   input wire logic [9:0] PRECISE_READ_ANGLE_IN,
   input wire logic [9:0] PRECISE_SWING_ANGLE_IN,
   input wire logic [13:0] FOCUS_POSITION_MM_IN,
   input wire logic SCAN_TICK_IN,
   input wire logic SCAN_GOOD_IN,
   input wire logic [1:0] MIRROR_CFG_IN,
   input wire logic [7:0] MIRROR_FIXED_POS_IN,
   input wire logic [7:0] RES_EVENT_SEL_IN,
   input wire logic [63:0] RES_PULSE_MS_IN,
   input wire logic RES_READY_IN,
   output logic READY_LED_OUT,
   output logic SENSOR_LED_OUT,
   output logic LASER_ON_OUT,
   output logic READ_RESULT_LED_OUT,
   output logic [3:0] RESULT_OUT,
   output logic MIRROR_SWING_OUT,
   output logic [7:0] MIRROR_REST_ANGLE_OUT,
   output logic [7:0] MIRROR_AMPL_OUT,
   output logic [3:0] MIRROR_FREQ_OUT,
   output logic [REC_W-1:0] RES_DATA_OUT,
   output logic RES_TO_HOST_OUT,
   output logic RES_TO_AUX_OUT,
   output logic RES_VALID_OUT,
   output logic [1:0] MODE_OUT,
   output logic SRC_SERIAL_OUT,
   output logic [6:0] PCT_QUALITY_OUT
);
   localparam int unsigned FW = REC_W + 2;
   strc_mode_t mode_q;
   logic sens_s1_q, sens_s2_q;
   logic [$clog2(MS_CYCLES)-1:0] ms_div_q;
   logic ms_tick;
   logic [15:0] st_ms_q;
   logic src_serial_q, std_dec_q, ser_gate_q, pulse_q, trig;
   logic pulse_end;
   logic [15:0] interval_q;
   logic [15:0] eval_ms_q;
   logic [6:0] scan_cnt_q, good_cnt_q, pct_q;
   logic eval_tick;
   // record capture and emitter
   logic [15:0] snap_interval_q;
   logic [6:0] snap_mean_q, snap_qual_q;
   logic [3:0] snap_count_q, snap_profile_q;
   logic [7:0] snap_type_q, snap_len_q, snap_angle_q;
   logic [15:0] snap_range_q, obj_num_q;
   logic [9:0] snap_rel_q, snap_eff_q, snap_cont_q, snap_pra_q, snap_psa_q;
   logic [13:0] snap_focus_q;
   logic snap_rev_q;
   logic rec_active_q, rec_pct_q;
   logic [4:0] rec_idx_q;
   logic [FIELD_W-1:0] rec_val;
   strc_tag_t rec_tag;
   logic rec_host, rec_aux, rec_last, rec_adv;
   logic multi_ok;
   logic [3:0] host_count;
   logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
   logic [FW-1:0] fifo_out;
   logic [15:0] led_ms_q;
   strc_band_t band, band_q;
   logic [15:0] blink_ms_q;
   logic blink_phase_q;
   logic [3:0] res_hit;

   assign ms_tick = (ms_div_q == ($clog2(MS_CYCLES))'(MS_CYCLES - 1));

   // first stage only feeds the second
   always_ff @(posedge REF_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         sens_s1_q <= 1'b0;
         sens_s2_q <= 1'b0;
         ms_div_q <= '0;
      end
      else
      begin
         sens_s1_q <= SENSOR_IN;
         sens_s2_q <= sens_s1_q;
         ms_div_q <= ms_tick ? '0 : ms_div_q + 1'b1;
      end
   end

   // mode sequencing; temporary loads only clear at power-up reset
   always_ff @(posedge REF_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         mode_q <= MODE_SELFTEST;
         st_ms_q <= '0;
         src_serial_q <= 1'b0;
         std_dec_q <= 1'b0;
      end
      else
      begin
         if (SRC_SERIAL_LOAD_IN)
         begin
            src_serial_q <= 1'b1;
         end
         if (STD_DECODER_LOAD_IN)
         begin
            std_dec_q <= 1'b1;
         end
         unique case (mode_q)
            MODE_SELFTEST:
            begin
               if (ms_tick)
               begin
                  st_ms_q <= st_ms_q + 16'h0001;
               end
               if (st_ms_q == SELFTEST_MS)
               begin
                  mode_q <= MODE_READING;
               end
            end
            MODE_READING:
            begin
               // refused while a pulse runs or without the standard decoder
               if (MODE_PERCENT_REQ_IN && std_dec_q && !pulse_q)
               begin
                  mode_q <= MODE_PERCENT;
               end
            end
            MODE_PERCENT:
            begin
               if (MODE_READING_REQ_IN)
               begin
                  mode_q <= MODE_READING;
               end
            end
            default:
            begin
               mode_q <= MODE_SELFTEST;
            end
         endcase
      end
   end

   assign trig = src_serial_q ? ser_gate_q : sens_s2_q;
   assign pulse_end = pulse_q && !(trig && mode_q == MODE_READING);

   // reading pulse and its interval time
   always_ff @(posedge REF_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         ser_gate_q <= 1'b0;
         pulse_q <= 1'b0;
         interval_q <= '0;
      end
      else
      begin
         if (src_serial_q && SER_START_IN)
         begin
            ser_gate_q <= 1'b1;
         end
         else if (SER_STOP_IN || !src_serial_q)
         begin
            ser_gate_q <= 1'b0;
         end
         pulse_q <= trig && mode_q == MODE_READING;
         if (!pulse_q)
         begin
            interval_q <= '0;
         end
         else if (ms_tick && interval_q != 16'hffff)
         begin
            interval_q <= interval_q + 16'h0001;
         end
      end
   end

   // percentage evaluation: good scans out of a block of 100 give percent
   assign eval_tick = mode_q == MODE_PERCENT && ms_tick && eval_ms_q == EVAL_PERIOD_MS - 16'h0001;
   always_ff @(posedge REF_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         eval_ms_q <= '0;
         scan_cnt_q <= '0;
         good_cnt_q <= '0;
         pct_q <= '0;
      end
      else if (mode_q != MODE_PERCENT)
      begin
         eval_ms_q <= '0;
         scan_cnt_q <= '0;
         good_cnt_q <= '0;
      end
      else
      begin
         if (ms_tick)
         begin
            eval_ms_q <= eval_tick ? '0 : eval_ms_q + 16'h0001;
         end
         if (SCAN_TICK_IN)
         begin
            if (scan_cnt_q == EVAL_SCANS - 7'h01)
            begin
               scan_cnt_q <= '0;
               good_cnt_q <= '0;
               pct_q <= good_cnt_q + 7'(SCAN_GOOD_IN);
            end
            else
            begin
               scan_cnt_q <= scan_cnt_q + 7'h01;
               good_cnt_q <= good_cnt_q + 7'(SCAN_GOOD_IN);
            end
         end
      end
   end

   // snapshot at record start so the emitter sees stable fields
   always_ff @(posedge REF_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         snap_interval_q <= '0;
         snap_mean_q <= '0;
         snap_count_q <= '0;
         snap_profile_q <= '0;
         snap_type_q <= '0;
         snap_qual_q <= '0;
         snap_len_q <= '0;
         snap_angle_q <= '0;
         snap_range_q <= '0;
         snap_rel_q <= '0;
         snap_eff_q <= '0;
         snap_cont_q <= '0;
         snap_rev_q <= 1'b0;
         snap_pra_q <= '0;
         snap_psa_q <= '0;
         snap_focus_q <= '0;
      end
      else if ((pulse_end || eval_tick) && !rec_active_q)
      begin
         snap_interval_q <= eval_tick ? EVAL_PERIOD_MS : interval_q;
         snap_mean_q <= eval_tick ? pct_q : MEAN_QUALITY_IN;
         snap_count_q <= CODE_COUNT_IN;
         snap_profile_q <= RANGE_PROFILE_INDEX_IN;
         snap_type_q <= SYMBOL_TYPE_IN;
         snap_qual_q <= QUALITY_IN;
         snap_len_q <= SYMBOL_LENGTH_IN;
         snap_angle_q <= SCAN_ANGLE_IN;
         snap_range_q <= OBJECT_RANGE_MM_IN;
         snap_rel_q <= RELIABILITY_IN;
         snap_eff_q <= DECODE_EFFORT_IN;
         snap_cont_q <= CODE_CONTINUITY_IN;
         snap_rev_q <= DECODE_ORIENTATION_FLAG_IN;
         snap_pra_q <= PRECISE_READ_ANGLE_IN;
         snap_psa_q <= PRECISE_SWING_ANGLE_IN;
         snap_focus_q <= FOCUS_POSITION_MM_IN;
      end
   end

   assign multi_ok = HOST_MIN_CODES_IN > 4'h1 && HOST_MAX_CODES_IN > 4'h1;
   assign host_count = (multi_ok || snap_count_q < 4'h2) ? snap_count_q : 4'h1;
   assign rec_last = (snap_count_q == '0) ? (rec_idx_q == LAST_SUMMARY_IDX)
                                          : (rec_idx_q == LAST_GOOD_IDX);

   // field selection for the record word at rec_idx_q
   always_comb
   begin
      rec_tag = strc_tag_t'(rec_idx_q);
      rec_val = '0;
      rec_aux = AUX_DIAG_MODE_IN;
      rec_host = !rec_pct_q && rec_idx_q >= 5'h02 && rec_idx_q != 5'h03;
      unique case (rec_idx_q)
         5'h00: rec_val = snap_interval_q;
         5'h01: rec_val = 16'(snap_mean_q);
         5'h02: rec_val = 16'(rec_pct_q ? snap_count_q : host_count);
         5'h03: rec_val = 16'(snap_profile_q);
         5'h04:
         begin
            if (snap_count_q == '0)
            begin
               rec_tag = TAG_NO_CODE;
               rec_host = 1'b0;
            end
            rec_val = 16'(snap_type_q);
         end
         5'h05: rec_val = 16'(snap_qual_q);
         5'h06: rec_val = VERDICT_GOOD;
         5'h07: rec_val = 16'(snap_len_q);
         5'h08: rec_val = 16'(snap_angle_q);
         5'h09: rec_val = snap_range_q;
         5'h0a: rec_val = 16'(snap_rel_q);
         5'h0b: rec_val = 16'(snap_eff_q);
         5'h0c: rec_val = 16'(snap_cont_q);
         5'h0d: rec_val = 16'(snap_rev_q);
         5'h0e: rec_val = 16'(snap_pra_q);
         5'h0f: rec_val = 16'(snap_psa_q);
         5'h10: rec_val = 16'(snap_focus_q);
         5'h11: rec_val = obj_num_q;
         default: rec_val = '0;
      endcase
   end

   // a word with no destination is skipped without waiting on the fifo
   assign rec_adv = rec_active_q && (fifo_in_ready || !(rec_host || rec_aux));

   always_ff @(posedge REF_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         rec_active_q <= 1'b0;
         rec_pct_q <= 1'b0;
         rec_idx_q <= '0;
         obj_num_q <= '0;
      end
      else if (!rec_active_q)
      begin
         // a pulse ending while a record drains is dropped, not queued
         if (pulse_end || eval_tick)
         begin
            rec_active_q <= 1'b1;
            rec_pct_q <= eval_tick;
            rec_idx_q <= '0;
         end
      end
      else if (rec_adv)
      begin
         rec_idx_q <= rec_idx_q + 5'h01;
         if (rec_last)
         begin
            rec_active_q <= 1'b0;
            obj_num_q <= obj_num_q + 16'h0001;
         end
      end
   end

   strc_fifo #(.WIDTH(FW), .DEPTH(FIFO_WORDS)) u_fifo (
      .clk_in(REF_CLK_IN),
      .rst_in(RST_IN),
      .wr_data_in({rec_host, rec_aux, rec_tag, rec_val}),
      .wr_valid_in(rec_active_q && (rec_host || rec_aux)),
      .wr_ready_out(fifo_in_ready),
      .rd_data_out(fifo_out),
      .rd_valid_out(fifo_out_valid),
      .rd_ready_in(fifo_out_ready)
   );

   assign fifo_out_ready = !RES_VALID_OUT || RES_READY_IN;

   always_ff @(posedge REF_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         RES_VALID_OUT <= 1'b0;
         RES_DATA_OUT <= '0;
         RES_TO_HOST_OUT <= 1'b0;
         RES_TO_AUX_OUT <= 1'b0;
      end
      else if (fifo_out_ready)
      begin
         RES_VALID_OUT <= fifo_out_valid;
         RES_DATA_OUT <= fifo_out[REC_W-1:0];
         RES_TO_HOST_OUT <= fifo_out[FW-1];
         RES_TO_AUX_OUT <= fifo_out[FW-2];
      end
   end

   // quality bands, boundaries go to the higher band
   always_comb
   begin
      if (pct_q >= Q_HIGH_PCT)
      begin
         band = BAND_STEADY;
      end
      else if (pct_q >= Q_MID_PCT)
      begin
         band = BAND_FAST;
      end
      else if (pct_q >= Q_LOW_PCT)
      begin
         band = BAND_SLOW;
      end
      else
      begin
         band = BAND_OFF;
      end
   end

   always_ff @(posedge REF_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         band_q <= BAND_OFF;
         blink_ms_q <= '0;
         blink_phase_q <= 1'b1;
         led_ms_q <= '0;
      end
      else
      begin
         band_q <= band;
         if (band != band_q)
         begin
            blink_ms_q <= '0;
            blink_phase_q <= 1'b1;
         end
         else if (ms_tick)
         begin
            if (blink_ms_q == ((band_q == BAND_FAST) ? BLINK_FAST_HALF_MS : BLINK_SLOW_HALF_MS)
                              - 16'h0001)
            begin
               blink_ms_q <= '0;
               blink_phase_q <= !blink_phase_q;
            end
            else
            begin
               blink_ms_q <= blink_ms_q + 16'h0001;
            end
         end
         if (mode_q == MODE_READING && !rec_active_q && pulse_end)
         begin
            led_ms_q <= READ_LED_MS;
         end
         else if (ms_tick && led_ms_q != '0)
         begin
            led_ms_q <= led_ms_q - 16'h0001;
         end
      end
   end

   // result outputs, each with its own event and length in ms
   for (genvar i = 0; i < 4; i++)
   begin : g_res
      logic [15:0] cnt_q;
      strc_event_t sel;
      assign sel = strc_event_t'(RES_EVENT_SEL_IN[2*i+1:2*i]);
      assign res_hit[i] = pulse_end && ((sel == EV_PULSE_END)
                       || (sel == EV_GOOD_READ && CODE_COUNT_IN != '0)
                       || (sel == EV_NO_READ && CODE_COUNT_IN == '0));
      always_ff @(posedge REF_CLK_IN or posedge RST_IN)
      begin
         if (RST_IN)
         begin
            cnt_q <= '0;
            RESULT_OUT[i] <= 1'b0;
         end
         else
         begin
            if (mode_q == MODE_PERCENT)
            begin
               cnt_q <= '0;
            end
            else if (res_hit[i])
            begin
               cnt_q <= RES_PULSE_MS_IN[16*i+15:16*i];
            end
            else if (ms_tick && cnt_q != '0)
            begin
               cnt_q <= cnt_q - 16'h0001;
            end
            RESULT_OUT[i] <= mode_q != MODE_PERCENT && cnt_q != '0;
         end
      end
   end

   // indicators and mirror commands, all registered
   always_ff @(posedge REF_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         READY_LED_OUT <= 1'b0;
         SENSOR_LED_OUT <= 1'b0;
         LASER_ON_OUT <= 1'b0;
         READ_RESULT_LED_OUT <= 1'b0;
         MIRROR_SWING_OUT <= 1'b0;
         MIRROR_REST_ANGLE_OUT <= MIRROR_REST;
         MIRROR_AMPL_OUT <= '0;
         MIRROR_FREQ_OUT <= '0;
         MODE_OUT <= MODE_SELFTEST;
         SRC_SERIAL_OUT <= 1'b0;
         PCT_QUALITY_OUT <= '0;
      end
      else
      begin
         READY_LED_OUT <= mode_q == MODE_READING;
         SENSOR_LED_OUT <= pulse_q && trig;
         LASER_ON_OUT <= (pulse_q && trig) || mode_q == MODE_PERCENT;
         READ_RESULT_LED_OUT <= (mode_q == MODE_PERCENT)
                                ? (band_q == BAND_STEADY
                                   || (band_q != BAND_OFF && blink_phase_q))
                                : led_ms_q != '0;
         MODE_OUT <= mode_q;
         SRC_SERIAL_OUT <= src_serial_q;
         PCT_QUALITY_OUT <= pct_q;
         if (MIRROR_CFG_IN == MIR_FIXED)
         begin
            MIRROR_SWING_OUT <= 1'b0;
            MIRROR_REST_ANGLE_OUT <= MIRROR_FIXED_POS_IN;
            MIRROR_AMPL_OUT <= '0;
            MIRROR_FREQ_OUT <= '0;
         end
         else if (mode_q == MODE_READING && MIRROR_CFG_IN == MIR_OSCILLATE)
         begin
            MIRROR_SWING_OUT <= 1'b1;
            MIRROR_REST_ANGLE_OUT <= MIRROR_REST;
            MIRROR_AMPL_OUT <= MIRROR_AMPL_DEG;
            MIRROR_FREQ_OUT <= MIRROR_FREQ_HZ;
         end
         else
         begin
            MIRROR_SWING_OUT <= 1'b0;
            MIRROR_REST_ANGLE_OUT <= MIRROR_REST;
            MIRROR_AMPL_OUT <= '0;
            MIRROR_FREQ_OUT <= '0;
         end
      end
   end
endmodule

// [testbench/scan_trigger_result_control_test.sv]
// self-checking bench for the trigger and result block
`timescale 1ns/1ps
module scan_trigger_result_control_test;
   logic REF_CLK_IN = 1'h0, RST_IN = 1'h1, SER_START_IN = 1'h0, SER_STOP_IN = 1'h0;
   logic SRC_SERIAL_LOAD_IN = 1'h0, STD_DECODER_LOAD_IN = 1'h0, MODE_READING_REQ_IN = 1'h0;
   logic MODE_PERCENT_REQ_IN = 1'h0, AUX_DIAG_MODE_IN = 1'h1, SCAN_TICK_IN = 1'h0, gate = 1'h0;
   logic SCAN_GOOD_IN = 1'h0, DECODE_ORIENTATION_FLAG_IN = 1'h1, stall = 1'h1, tick_en = 1'h0;
   logic [3:0] HOST_MIN_CODES_IN = 4'h2, HOST_MAX_CODES_IN = 4'h2, CODE_COUNT_IN = 4'h1;
   logic [3:0] RANGE_PROFILE_INDEX_IN = 4'h1, RESULT_OUT, MIRROR_FREQ_OUT;
   logic [6:0] MEAN_QUALITY_IN = 7'h51, QUALITY_IN = 7'h64, PCT_QUALITY_OUT;
   logic [7:0] SYMBOL_TYPE_IN = 8'h1, SYMBOL_LENGTH_IN = 8'ha, SCAN_ANGLE_IN = 8'h34, words;
   logic [7:0] MIRROR_FIXED_POS_IN = 8'h32, RES_EVENT_SEL_IN = 8'he4, MIRROR_REST_ANGLE_OUT;
   logic [9:0] RELIABILITY_IN = '0, DECODE_EFFORT_IN = '0, CODE_CONTINUITY_IN = '0;
   logic [9:0] PRECISE_READ_ANGLE_IN = '0, PRECISE_SWING_ANGLE_IN = '0;
   logic [13:0] FOCUS_POSITION_MM_IN = '0;
   logic [15:0] OBJECT_RANGE_MM_IN = '0;
   logic [63:0] RES_PULSE_MS_IN = 64'h2_0002_0002_0002;
   logic [1:0] MIRROR_CFG_IN = 2'h0, MODE_OUT;
   logic SENSOR_IN, RES_READY_IN, READY_LED_OUT, SENSOR_LED_OUT, LASER_ON_OUT, MIRROR_SWING_OUT;
   logic READ_RESULT_LED_OUT, RES_TO_HOST_OUT, RES_TO_AUX_OUT, RES_VALID_OUT, SRC_SERIAL_OUT;
   logic [7:0] MIRROR_AMPL_OUT;
   logic [20:0] RES_DATA_OUT;
   logic [22:0] last;
   int miscompares = 0, n_checks = 0;
   // ms shortened to 10 cycles
   strc_top #(.MS_CYCLES(10)) dut (.*);
   strc_partner far (.clk_in(REF_CLK_IN), .gate_in(gate), .stall_in(stall),
      .valid_in(RES_VALID_OUT), .word_in({RES_TO_HOST_OUT, RES_TO_AUX_OUT, RES_DATA_OUT}),
      .sensor_out(SENSOR_IN), .ready_out(RES_READY_IN), .words_out(words), .last_out(last));
   initial forever #50 REF_CLK_IN = ~REF_CLK_IN;
   initial #1600 RST_IN = 1'h0;
   always @(negedge REF_CLK_IN) SCAN_TICK_IN <= tick_en & ~SCAN_TICK_IN;
   task automatic tick(input int n);
      repeat (n) @(negedge REF_CLK_IN);
   endtask
   task automatic pulse(ref logic s);
      s = 1'h1;
      tick(1);
      s = 1'h0;
   endtask
   task automatic chk(input logic [22:0] e, input logic [22:0] a);
      n_checks++;
      if (e !== a)
      begin
         miscompares++;
         $display("[FAIL] %0t exp %h got %h", $time, e, a);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (30000) @(posedge REF_CLK_IN);
      miscompares++;
      stop_test;
   end
   initial
   begin
      tick(126);
      chk(3'h3, {MODE_OUT, READY_LED_OUT});
      chk(21'h132141, {MIRROR_SWING_OUT, MIRROR_REST_ANGLE_OUT, MIRROR_AMPL_OUT, MIRROR_FREQ_OUT});
      $display("boot end");
      gate = 1'h1;
      tick(8);
      chk(2'h3, {SENSOR_LED_OUT, LASER_ON_OUT});
      gate = 1'h0;
      tick(12);
      chk(5'h1a, {READ_RESULT_LED_OUT, RESULT_OUT});
      tick(100);
      chk(8'h12, words);
      chk(23'h710000, last);
      $display("sensor end");
      {CODE_COUNT_IN, AUX_DIAG_MODE_IN, stall} = 6'h0;
      pulse(SRC_SERIAL_LOAD_IN);
      pulse(SER_START_IN);
      tick(3);
      chk(2'h3, {SENSOR_LED_OUT, SRC_SERIAL_OUT});
      pulse(SER_STOP_IN);
      tick(2);
      chk(2'h0, {SENSOR_LED_OUT, LASER_ON_OUT});
      tick(10);
      chk(4'hc, RESULT_OUT);
      tick(100);
      chk(8'h13, words);
      chk(23'h420000, last);
      $display("serial end");
      {AUX_DIAG_MODE_IN, SCAN_GOOD_IN, tick_en} = 3'h7;
      pulse(STD_DECODER_LOAD_IN);
      pulse(MODE_PERCENT_REQ_IN);
      tick(20100);
      chk(14'h2064, {MODE_OUT, READY_LED_OUT, RESULT_OUT, PCT_QUALITY_OUT});
      chk(1'h1, READ_RESULT_LED_OUT);
      chk(1'h1, words > 8'h13);
      chk(7'h32, last[22:16]);
      pulse(MODE_READING_REQ_IN);
      tick(2);
      chk(3'h3, {MODE_OUT, READY_LED_OUT});
      $display("percentage end");
      stop_test;
   end
endmodule
bind strc_top strc_properties props (.*);

// [testbench/strc_partner.sv]
// trigger sensor and result sink model
`timescale 1ns/1ps
module strc_partner
(
   input logic clk_in,
   input logic gate_in,
   input logic stall_in,
   input logic valid_in,
   input logic [22:0] word_in,
   output logic sensor_out = 1'h0,
   output logic ready_out = 1'h0,
   output logic [7:0] words_out = 8'h0,
   output logic [22:0] last_out = 23'h0
);
   always @(posedge clk_in) sensor_out <= gate_in;
   // last accepted word with its destinations, so content can be checked after a record
   always @(posedge clk_in) if (valid_in && ready_out) last_out <= word_in;
   // stalled sink is ready every other cycle, so it takes each word on alternate cycles
   always @(posedge clk_in) ready_out <= !stall_in || !ready_out;
   always @(posedge clk_in) words_out <= words_out + 8'(valid_in && ready_out);
endmodule

// [testbench/strc_properties.sv]
// port checks for the trigger and result block
`timescale 1ns/1ps
module strc_properties
(
   input logic REF_CLK_IN,
   input logic RST_IN,
   input logic RES_READY_IN,
   input logic [1:0] MIRROR_CFG_IN,
   input logic [1:0] MODE_OUT,
   input logic READY_LED_OUT,
   input logic READ_RESULT_LED_OUT,
   input logic [3:0] RESULT_OUT,
   input logic MIRROR_SWING_OUT,
   input logic [7:0] MIRROR_REST_ANGLE_OUT,
   input logic [20:0] RES_DATA_OUT,
   input logic RES_VALID_OUT,
   input logic SRC_SERIAL_OUT,
   input logic [6:0] PCT_QUALITY_OUT
);
   default clocking @(posedge REF_CLK_IN);
   endclocking
   default disable iff (RST_IN);
   ready_mode_a: assert property ($rose(READY_LED_OUT) |-> MODE_OUT == 2'h1)
      else $error("ready early");
   mirror_swing_a: assert property ((MODE_OUT == 2'h1 && MIRROR_CFG_IN == 2'h0)[*3]
      |-> MIRROR_SWING_OUT && MIRROR_REST_ANGLE_OUT == 8'h32) else $error("no swing");
   mirror_park_a: assert property ((MODE_OUT == 2'h2 && MIRROR_CFG_IN != 2'h2)[*3]
      |-> !MIRROR_SWING_OUT && MIRROR_REST_ANGLE_OUT == 8'h32) else $error("not parked");
   pct_silent_a: assert property ((MODE_OUT == 2'h2)[*2] |-> RESULT_OUT == 4'h0)
      else $error("result live");
   pct_ready_a: assert property ((MODE_OUT == 2'h2)[*2] |-> !READY_LED_OUT)
      else $error("ready lit");
   word_hold_a: assert property (RES_VALID_OUT && !RES_READY_IN
      |=> RES_VALID_OUT && $stable(RES_DATA_OUT)) else $error("word moved");
   serial_keep_a: assert property (!$fell(SRC_SERIAL_OUT)) else $error("source lost");
   led_steady_a: assert property ((MODE_OUT == 2'h2 && PCT_QUALITY_OUT >= 7'h5a)[*3]
      |-> READ_RESULT_LED_OUT) else $error("led not steady");
   cover property (MODE_OUT == 2'h2 && READ_RESULT_LED_OUT);
   cover property (RES_VALID_OUT && !RES_READY_IN);
   cover property ($rose(SRC_SERIAL_OUT));
endmodule
